//--- src/tilpu_top.sv
// Timer with prescaler, interrupt request logic and stop/wait effects.
// Assumes one 10 MHz clock as instruction-cycle clock and an Avalon-MM
// master standing in for the CPU core.
//
// Overview of operation
// - 8-bit down counter fed through prescaler
// - Counter reaching zero sets request flag
// - Timer interrupt needs flag, both masks clear
// - Timer vector 1FF8, 1FF6 in wait
// - Counter keeps counting after zero
// - Counter reads never disturb counting
// - Flag sticks until software clears
// - Write with bit 3 clears prescaler
// - Select code picks divide 1 to 128
// - Mode 00 counts internal clock, also wait
// - Pin enable only gates clock by pin
// - Source select only blocks all counting
// - Both set counts pin falling edges
// - Power-on and stop load F0
// - Stop halts timer, alters flags, mask
// - Wait keeps timer, clears CPU mask
// - External first; then wait, then normal timer vector
// - Reset clears flag, sets mask only
// - Prescaler clear bit reads zero
// - Low external pin interrupts, vector 1FFA
// - Software trap ignores CPU mask, 1FFC
// - Masked requests latched until mask cleared
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tilpu_defs.svh"

module tilpu_top #(
    parameter bit EDGE_ONLY = 1'b0,   // External trigger build option
    parameter int PS_WIDTH  = 7,
    parameter int CNT_WIDTH = 8
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_POR_N,
    input  wire logic        I_TIMER_PIN,
    input  wire logic        I_EXT_IRQ_N,
    input  wire logic [3:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    output logic             O_CPU_IRQ,
    output logic      [15:0] O_VECTOR,
    output logic             O_OSC_RUN,
    output logic             O_CORE_CLK_EN
);

    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [1:0] por_sync_reg;
    logic       por_n;

    // Two-stage release of external reset
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1] && por_sync_reg[1];  // Power-on resets this domain too

    // Two-stage release of power-on reset
    always_ff @(posedge I_REF_CLK or negedge I_POR_N) begin
        if (!I_POR_N) begin
            por_sync_reg <= 2'h0;
        end else begin
            por_sync_reg <= {por_sync_reg[0], 1'b1};
        end
    end
    assign por_n = por_sync_reg[1];

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wr_ctrl;
    logic wr_count;
    logic wr_cpu;

    assign wr_ctrl  = I_AVS_WRITE && I_AVS_BYTEENABLE[0] && (I_AVS_ADDRESS == `TILPU_OFS_CTRL);
    assign wr_count = I_AVS_WRITE && I_AVS_BYTEENABLE[0] && (I_AVS_ADDRESS == `TILPU_OFS_COUNT);
    assign wr_cpu   = I_AVS_WRITE && I_AVS_BYTEENABLE[0] && (I_AVS_ADDRESS == `TILPU_OFS_CPU);

    // Commands on the CPU control word, one cycle each
    logic cmd_stop;
    logic cmd_wait;
    logic cmd_seti;
    logic cmd_clri;
    logic cmd_ack;
    logic cmd_trap;
    logic cmd_wake;

    assign cmd_stop = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_STOP];
    assign cmd_wait = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_WAIT];
    assign cmd_seti = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_SETI];
    assign cmd_clri = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_CLRI];
    assign cmd_ack  = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_ACK];
    assign cmd_trap = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_TRAP];
    assign cmd_wake = wr_cpu && I_AVS_WRITEDATA[`TILPU_CMD_WAKE];

    ////////////////////////////////////////////////////////////////////
    // Power state
    tilpu_pkg::tilpu_power_t power_reg;
    tilpu_pkg::tilpu_power_t power_next;
    logic                    irq_take;

    // Stop and wait latches
    always_comb begin
        power_next = power_reg;
        case (power_reg)
            tilpu_pkg::TILPU_RUN: begin
                if (cmd_stop) begin
                    power_next = tilpu_pkg::TILPU_STOP;
                end else if (cmd_wait) begin
                    power_next = tilpu_pkg::TILPU_WAIT;
                end
            end
            tilpu_pkg::TILPU_WAIT, tilpu_pkg::TILPU_STOP: begin
                if (irq_take || cmd_wake) begin
                    power_next = tilpu_pkg::TILPU_RUN;
                end
            end
            default: begin
                power_next = tilpu_pkg::TILPU_RUN;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            power_reg <= tilpu_pkg::TILPU_RUN;
        end else begin
            power_reg <= power_next;
        end
    end

    logic stopped;
    logic waiting;
    assign stopped = (power_reg == tilpu_pkg::TILPU_STOP);
    assign waiting = (power_reg == tilpu_pkg::TILPU_WAIT);

    assign O_OSC_RUN = !stopped;
    assign O_CORE_CLK_EN = (power_reg == tilpu_pkg::TILPU_RUN);

    ////////////////////////////////////////////////////////////////////
    // Control register
    logic       req_flag_reg;
    logic       req_mask_reg;
    logic       src_sel_reg;
    logic       pin_en_reg;
    logic [2:0] ps_sel_reg;
    logic       zero_hit;

    // zero sets flag; set wins over clear
    // reset and stop touch flag and mask only
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            req_flag_reg <= 1'b0;
            req_mask_reg <= 1'b1;
        end else if (cmd_stop) begin
            req_flag_reg <= 1'b0;
            req_mask_reg <= 1'b1;
        end else begin
            if (zero_hit) begin
                req_flag_reg <= 1'b1;
            end else if (wr_ctrl) begin
                req_flag_reg <= I_AVS_WRITEDATA[`TILPU_REQ_BIT];
            end
            if (wr_ctrl) begin
                req_mask_reg <= I_AVS_WRITEDATA[`TILPU_MASK_BIT];
            end
        end
    end

    // Mode and select bits: power-on only, untouched by reset
    always_ff @(posedge I_REF_CLK or negedge por_n) begin
        if (!por_n) begin
            src_sel_reg <= 1'b0;
            pin_en_reg  <= 1'b0;
            ps_sel_reg  <= 3'h0;
        end else if (wr_ctrl) begin
            src_sel_reg <= I_AVS_WRITEDATA[`TILPU_SRC_BIT];
            pin_en_reg  <= I_AVS_WRITEDATA[`TILPU_PIN_BIT];
            ps_sel_reg  <= I_AVS_WRITEDATA[`TILPU_SEL_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timer input selection
    logic pin_d_reg;
    logic tick_in;

    // Pin history for falling edges
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= I_TIMER_PIN;
        end
    end

    always_comb begin
        case ({src_sel_reg, pin_en_reg})
            // internal clock, runs in wait too
            2'h0: tick_in = 1'b1;
            2'h1: tick_in = I_TIMER_PIN;
            2'h2: tick_in = 1'b0;
            2'h3: tick_in = pin_d_reg && !I_TIMER_PIN;
            default: tick_in = 1'b0;
        endcase
        if (stopped) begin
            tick_in = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Prescaler
    logic [PS_WIDTH-1:0] ps_reg;
    logic [PS_WIDTH:0]   ps_ext;
    logic [PS_WIDTH:0]   tap_hit;
    logic                cnt_tick;

    // cleared by control write with bit 3 and by stop
    always_ff @(posedge I_REF_CLK or negedge por_n) begin
        if (!por_n) begin
            ps_reg <= '0;
        end else if (cmd_stop || (wr_ctrl && I_AVS_WRITEDATA[`TILPU_PCLR_BIT])) begin
            ps_reg <= '0;
        end else if (tick_in) begin
            ps_reg <= ps_reg + 1'b1;
        end
    end

    // tap n fires every 2**n input ticks
    assign ps_ext = {ps_reg, 1'b1};
    genvar gi;
    generate
        for (gi = 0; gi <= PS_WIDTH; gi = gi + 1) begin : g_tap
            assign tap_hit[gi] = &ps_ext[gi:0];
        end
    endgenerate
    assign cnt_tick = tick_in && tap_hit[ps_sel_reg];

    ////////////////////////////////////////////////////////////////////
    // Counter
    logic [CNT_WIDTH-1:0] count_reg;

    always_ff @(posedge I_REF_CLK or negedge por_n) begin
        if (!por_n) begin
            count_reg <= `TILPU_COUNT_LOAD;
        end else if (cmd_stop) begin
            count_reg <= `TILPU_COUNT_LOAD;
        end else if (wr_count) begin
            count_reg <= I_AVS_WRITEDATA[CNT_WIDTH-1:0];
        end else if (cnt_tick) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign zero_hit = cnt_tick && !wr_count && !cmd_stop && (count_reg == {{(CNT_WIDTH-1){1'b0}}, 1'b1});

    ////////////////////////////////////////////////////////////////////
    // Interrupt logic
    logic cpu_mask_reg;
    logic ext_latch_reg;
    logic ext_d_reg;
    logic ext_req;
    logic tmr_req;
    logic trap_reg;

    // External edge detector history
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_d_reg <= 1'b1;
        end else begin
            ext_d_reg <= I_EXT_IRQ_N;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_latch_reg <= 1'b0;
        end else if (ext_d_reg && !I_EXT_IRQ_N) begin
            ext_latch_reg <= 1'b1;
        end else if (irq_take && ext_req) begin
            ext_latch_reg <= 1'b0;
        end
    end

    // level and edge, or edge only
    assign ext_req = ext_latch_reg || (!EDGE_ONLY && !I_EXT_IRQ_N);
    assign tmr_req = req_flag_reg && !req_mask_reg;
    assign irq_take = !cpu_mask_reg && (ext_req || tmr_req);

    // CPU mask: reset sets, take sets, stop and wait clear
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cpu_mask_reg <= 1'b1;
        end else if (irq_take || cmd_trap || cmd_seti) begin
            cpu_mask_reg <= 1'b1;
        end else if (cmd_stop || cmd_wait || cmd_clri) begin
            cpu_mask_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            trap_reg <= 1'b0;
        end else if (cmd_trap) begin
            trap_reg <= 1'b1;
        end else if (cmd_ack) begin
            trap_reg <= 1'b0;
        end
    end

    // Vector of the latest take or trap, kept past acknowledge until the next one
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_VECTOR  <= `TILPU_VEC_RESET;
            O_CPU_IRQ <= 1'b0;
        end else if (irq_take) begin
            O_CPU_IRQ <= 1'b1;
            if (ext_req) begin
                O_VECTOR <= `TILPU_VEC_EXT;
            end else if (waiting) begin
                O_VECTOR <= `TILPU_VEC_TMR_WAIT;
            end else begin
                O_VECTOR <= `TILPU_VEC_TMR;
            end
        end else if (cmd_trap) begin
            O_CPU_IRQ <= 1'b1;
            O_VECTOR  <= `TILPU_VEC_TRAP;
        end else if (cmd_ack) begin
            O_CPU_IRQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Avalon slave: reads take one wait state, writes none
    logic        rd_done_reg;
    logic [31:0] rd_mux;

    assign O_AVS_WAITREQUEST = I_AVS_READ && !rd_done_reg;

    always_comb begin
        case (I_AVS_ADDRESS)
            `TILPU_OFS_CTRL:   rd_mux = {24'h0, req_flag_reg, req_mask_reg, src_sel_reg,
                                         pin_en_reg, 1'b0, ps_sel_reg};
            `TILPU_OFS_COUNT:  rd_mux = {{(32-CNT_WIDTH){1'b0}}, count_reg};
            `TILPU_OFS_CPU:    rd_mux = {24'h0, 1'b0, trap_reg, O_CPU_IRQ, ext_req,
                                         cpu_mask_reg, stopped, waiting, 1'b0};
            `TILPU_OFS_VECTOR: rd_mux = {16'h0, O_VECTOR};
            default:           rd_mux = 32'h0;
        endcase
    end

    // flop samples the selected register on every clock, not just during a read
    always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_reg    <= 1'b0;
            O_AVS_READDATA <= 32'h0;
        end else begin
            rd_done_reg    <= I_AVS_READ && !rd_done_reg;
            O_AVS_READDATA <= rd_mux;
        end
    end

endmodule

//--- shared/tilpu_defs.svh
// Constants of the timer, interrupt and low-power unit.
// Assumes inclusion by bare name; definitions only.
`ifndef TILPU_DEFS_SVH
`define TILPU_DEFS_SVH

// Avalon word offsets (byte addresses)
`define TILPU_OFS_CTRL      4'h0
`define TILPU_OFS_COUNT     4'h4
`define TILPU_OFS_CPU       4'h8
`define TILPU_OFS_VECTOR    4'hc

// Control register field positions
`define TILPU_REQ_BIT       7
`define TILPU_MASK_BIT      6
`define TILPU_SRC_BIT       5
`define TILPU_PIN_BIT       4
`define TILPU_PCLR_BIT      3
`define TILPU_SEL_MSB       2

// CPU control word fields (write: one-cycle commands)
`define TILPU_CMD_STOP      0
`define TILPU_CMD_WAIT      1
`define TILPU_CMD_SETI      2
`define TILPU_CMD_CLRI      3
`define TILPU_CMD_ACK       4
`define TILPU_CMD_TRAP      5
`define TILPU_CMD_WAKE      6

// Values
`define TILPU_COUNT_LOAD    8'hf0
`define TILPU_VEC_RESET     16'h1ffe
`define TILPU_VEC_TRAP      16'h1ffc
`define TILPU_VEC_EXT       16'h1ffa
`define TILPU_VEC_TMR       16'h1ff8
`define TILPU_VEC_TMR_WAIT  16'h1ff6

`endif

//--- shared/tilpu_pkg.sv
// Types of the timer, interrupt and low-power unit.
// Assumes nothing beyond a SystemVerilog compiler.
package tilpu_pkg;
    typedef enum logic [1:0] {
        TILPU_RUN,
        TILPU_WAIT,
        TILPU_STOP
    } tilpu_power_t;
endpackage

//--- tb/tilpu_far_model.sv
// Far-side model: external request source and timer pin.
// Assumes a bench that calls its tasks from one process.
`timescale 1ns/1ps
module tilpu_far_model (
    input  wire logic i_clk,
    output logic      o_ext_irq_n,
    output logic      o_timer_pin
);
    // Idle levels: request high, pin low
    initial begin
        o_ext_irq_n = 1'b1;
        o_timer_pin = 1'b0;
    end
    // Pin pulses, two cycles high, two low
    task automatic pulses(input int n);
        repeat (2 * n) begin
            repeat (2) @(posedge i_clk);
            o_timer_pin <= ~o_timer_pin;
        end
    endtask
    task automatic set_ext(input logic lvl);
        @(posedge i_clk);
        o_ext_irq_n <= lvl;
    endtask
endmodule

//--- tb/tilpu_top_properties.sv
// Checker of the timer and interrupt unit, bound to its top.
// Assumes the constants header and the top's port names.
`timescale 1ns/1ps
`include "tilpu_defs.svh"
module tilpu_top_properties (
    input wire logic        I_REF_CLK,
    input wire logic        I_NRST,
    input wire logic        I_POR_N,
    input wire logic        I_TIMER_PIN,
    input wire logic        I_EXT_IRQ_N,
    input wire logic [3:0]  I_AVS_ADDRESS,
    input wire logic        I_AVS_READ,
    input wire logic        I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0]  I_AVS_BYTEENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic        O_AVS_WAITREQUEST,
    input wire logic        O_CPU_IRQ,
    input wire logic [15:0] O_VECTOR,
    input wire logic        O_OSC_RUN,
    input wire logic        O_CORE_CLK_EN
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST || !I_POR_N);
    // Decoded bus requests
    wire cpu_wr = I_AVS_WRITE && I_AVS_ADDRESS == `TILPU_OFS_CPU && I_AVS_BYTEENABLE[0];
    wire ctl_wr = I_AVS_WRITE && I_AVS_ADDRESS == `TILPU_OFS_CTRL && I_AVS_BYTEENABLE[0];
    wire ctl_rd = I_AVS_READ && I_AVS_ADDRESS == `TILPU_OFS_CTRL;
    ////////////////////////////////////////////////////////////
    AST_PCLR_READS_ZERO: assert property (ctl_rd && !O_AVS_WAITREQUEST |-> !O_AVS_READDATA[3])
        else $error("prescaler clear bit read as one");
    AST_CTRL_READBACK: assert property (ctl_wr ##2 (ctl_rd && O_AVS_WAITREQUEST) ##1 (ctl_rd && !O_AVS_WAITREQUEST) |->
        {O_AVS_READDATA[6:4], O_AVS_READDATA[2:0]} == $past({I_AVS_WRITEDATA[6:4], I_AVS_WRITEDATA[2:0]}, 3))
        else $error("control bits not read back");
    AST_VECTOR_LEGAL: assert property (O_VECTOR inside {16'h1ffe, 16'h1ffc, 16'h1ffa, 16'h1ff8, 16'h1ff6})
        else $error("vector outside table");
    AST_RESET_STATE: assert property ($rose(I_NRST) |-> O_VECTOR == 16'h1ffe && !O_CPU_IRQ)
        else $error("reset left request or vector");
    AST_IRQ_HOLDS: assert property (O_CPU_IRQ && !(cpu_wr && I_AVS_WRITEDATA[4]) |=> O_CPU_IRQ)
        else $error("request dropped without ack");
    AST_TAKE_VECTOR: assert property ($rose(O_CPU_IRQ) |-> O_VECTOR != 16'h1ffe)
        else $error("request taken with reset vector");
    AST_STOP_OSC: assert property (cpu_wr && I_AVS_WRITEDATA[0] |=> !O_OSC_RUN)
        else $error("stop left oscillator running");
    AST_WAIT_CORE: assert property (cpu_wr && I_AVS_WRITEDATA[1] |=> !O_CORE_CLK_EN || $rose(O_CPU_IRQ))
        else $error("wait left core clock on");
    // Main scenarios reached
    C_WAIT_TIMER: cover property ($rose(O_CPU_IRQ) && O_VECTOR == 16'h1ff6);
    C_EXT_TAKE: cover property ($rose(O_CPU_IRQ) && O_VECTOR == 16'h1ffa);
    C_STOPPED: cover property (!O_OSC_RUN);
endmodule
bind tilpu_top tilpu_top_properties u_props (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_POR_N(I_POR_N), .I_TIMER_PIN(I_TIMER_PIN),
    .I_EXT_IRQ_N(I_EXT_IRQ_N), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_CPU_IRQ(O_CPU_IRQ),
    .O_VECTOR(O_VECTOR), .O_OSC_RUN(O_OSC_RUN), .O_CORE_CLK_EN(O_CORE_CLK_EN)
);

//--- tb/tilpu_top_tb.sv
// Self-checking bench of the timer and interrupt unit.
// Assumes the design, the far-side model and the bound checker.
`timescale 1ns/1ps
`include "tilpu_defs.svh"
module tilpu_top_tb;
    localparam logic [3:0] CTL = `TILPU_OFS_CTRL, CNT = `TILPU_OFS_COUNT, CPU = `TILPU_OFS_CPU;
    logic        clk, nrst, por_n, rd, wr, wreq, irq, osc, core;
    logic [3:0]  addr, ben;
    logic [31:0] wdata, rdata;
    logic [15:0] vec;
    logic [7:0]  v;
    wire         pin, ext_n;
    int          n_mismatch = 0;
    int          compares = 0;
    tilpu_top dut (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_POR_N(por_n), .I_TIMER_PIN(pin), .I_EXT_IRQ_N(ext_n),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(ben), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .O_CPU_IRQ(irq),
        .O_VECTOR(vec), .O_OSC_RUN(osc), .O_CORE_CLK_EN(core)
    );
    tilpu_far_model far (.i_clk(clk), .o_ext_irq_n(ext_n), .o_timer_pin(pin));
    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One Avalon transfer, read data left in v
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d = 8'h00,
                       input logic [3:0] be = 4'hf);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h000000, d};
        ben <= be;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        v = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic cpu(input int b);
        bus(1'b1, CPU, 8'h01 << b);
    endtask
    // Bounded wait for a take, vector check, ack
    task automatic take(input logic [15:0] exp);
        for (int n = 0; n < 30 && irq !== 1'b1; n++)
            @(posedge clk);
        chk("irq", 16'(irq), 16'h0001);
        chk("vector", vec, exp);
        cpu(`TILPU_CMD_ACK);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(1'b0, CTL);
        chk("ctrl", 16'(v), 16'h0040);
        chk("vector", vec, `TILPU_VEC_RESET);
        $display("reset test done");
    endtask
    task automatic t_prescale;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, CTL, 8'h48 | 8'(s));
            bus(1'b1, CNT, 8'hff);
            repeat (16 << s) @(posedge clk);
            bus(1'b0, CNT);
            chk("ticks", 16'((8'hff - v) inside {[8'h0f:8'h13]}), 16'h0001);
        end
        $display("prescale test done");
    endtask
    task automatic t_modes;
        int exp [4] = '{33, 16, 0, 8};
        int d;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, CTL, 8'h48 | 8'(m << 4));
            bus(1'b1, CNT, 8'hff);
            far.pulses(8);
            bus(1'b0, CNT);
            d = 255 - int'(v);
            chk("mode", 16'(d >= exp[m] - 2 && d <= exp[m] + 2), 16'h0001);
        end
        $display("mode test done");
    endtask
    task automatic t_flag;
        bus(1'b1, CTL, 8'h48);
        bus(1'b1, CNT, 8'h05);
        repeat (8) @(posedge clk);
        bus(1'b0, CTL);
        chk("ctrl", 16'(v), 16'h00c0);
        bus(1'b0, CNT);
        chk("wrap", 16'(v[7:4]), 16'h000f);
        bus(1'b1, CTL, 8'h40);
        bus(1'b0, CTL);
        chk("ctrl", 16'(v), 16'h0040);
        $display("flag test done");
    endtask
    task automatic t_irq;
        bus(1'b1, CTL, 8'h08);
        bus(1'b1, CNT, 8'h04);
        repeat (10) @(posedge clk);
        chk("irq", 16'(irq), 16'h0000);
        cpu(`TILPU_CMD_CLRI);
        take(`TILPU_VEC_TMR);
        far.set_ext(1'b0);
        bus(1'b1, CTL, 8'h80);
        repeat (4) @(posedge clk);
        chk("irq", 16'(irq), 16'h0000);
        cpu(`TILPU_CMD_WAIT);
        take(`TILPU_VEC_EXT);
        far.set_ext(1'b1);
        cpu(`TILPU_CMD_CLRI);
        take(`TILPU_VEC_TMR);
        bus(1'b1, CTL, 8'h08);
        bus(1'b1, CNT, 8'h06);
        cpu(`TILPU_CMD_WAIT);
        take(`TILPU_VEC_TMR_WAIT);
        bus(1'b1, CTL, 8'h40);
        cpu(`TILPU_CMD_TRAP);
        take(`TILPU_VEC_TRAP);
        $display("interrupt test done");
    endtask
    task automatic t_stop;
        bus(1'b1, CTL, 8'h80);
        cpu(`TILPU_CMD_STOP);
        repeat (5) @(posedge clk);
        chk("osc", 16'(osc), 16'h0000);
        bus(1'b0, CNT);
        chk("count", 16'(v), 16'h00f0);
        bus(1'b0, CTL);
        chk("ctrl", 16'(v), 16'h0040);
        bus(1'b0, CPU);
        chk("cpu mask", 16'(v[3]), 16'h0000);
        cpu(`TILPU_CMD_WAKE);
        @(posedge clk);
        chk("run", 16'({osc, core}), 16'h0003);
        cpu(`TILPU_CMD_SETI);
        bus(1'b0, CPU);
        chk("cpu mask", 16'(v[3]), 16'h0001);
        $display("stop test done");
    endtask
    task automatic t_rst;
        bus(1'b1, CTL, 8'h33);
        bus(1'b1, CNT, 8'h55);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, CTL);
        chk("ctrl", 16'(v), 16'h0073);
        bus(1'b0, CNT);
        chk("count", 16'(v), 16'h0055);
        chk("vector", vec, `TILPU_VEC_RESET);
        bus(1'b1, CTL, 8'h07, 4'he);
        bus(1'b0, CTL);
        chk("lane", 16'(v), 16'h0073);
        bus(1'b0, 4'h2);
        chk("unmapped", 16'(v), 16'h0000);
        $display("reset mid-run test done");
    endtask
    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Reset, then the tests in order
    initial begin
        nrst = 1'b0;
        por_n = 1'b0;
        addr = 4'h0;
        ben = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h00000000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_prescale;
        t_modes;
        t_flag;
        t_irq;
        t_stop;
        t_rst;
        complete_run;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run;
    end
endmodule
